// ==== common/bst_defs.svh ====
// Constants for the boundary-scan test access port
`ifndef BST_DEFS_SVH
`define BST_DEFS_SVH
`define BST_CHAIN_LEN     57
`define BST_IR_W          5
`define BST_AUX_LEN       8
`define BST_OP_EXTEST     5'h00
`define BST_OP_SAMPLE     5'h01
`define BST_OP_INT_SCAN   5'h02
`define BST_OP_CLAMP      5'h04
`define BST_OP_HIGHZ      5'h05
`define BST_OP_PRIVATE    5'h09
`define BST_OP_MEM_TEST   5'h0A
`define BST_OP_IDENT      5'h0C
`define BST_OP_BYPASS     5'h1F
`define BST_IR_CAPTURE    5'h01
`define BST_ID_FIXED      1'h1
`define BST_BYP_CAPTURE   1'h0
`define BST_MASK_OUT2     57'h040000000000003
`define BST_MASK_INPUT    57'h000000000000038
`define BST_MASK_CTRL     57'h12A200555501000
`define BST_MASK_BIDIR    57'h095869AAAAFEBC0
`define BST_CTRL_LOW      12
`define BST_GPIO_FIRST    19
`define BST_GPIO_LAST     34
`define BST_CTRL_HIGH     45
`define BST_CTRL_HI_LAST  47
`endif

// ==== common/bst_pkg.sv ====
// Types shared by the boundary-scan test access port
package bst_pkg;
    typedef enum logic [3:0] {
        BST_TLR, BST_RTI, BST_SEL_DR, BST_CAP_DR, BST_SH_DR, BST_EX1_DR,
        BST_PAU_DR, BST_EX2_DR, BST_UPD_DR, BST_SEL_IR, BST_CAP_IR,
        BST_SH_IR, BST_EX1_IR, BST_PAU_IR, BST_EX2_IR, BST_UPD_IR
    } bst_state_t;

    typedef enum logic [2:0] {
        BST_SEL_BYP, BST_SEL_BSR, BST_SEL_ID, BST_SEL_AUX
    } bst_sel_t;

    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
        logic trst_n;
    } bst_tap_pins_t;
endpackage

// ==== rtl/bst_tap.sv ====
// Boundary-scan test access port: controller, instruction and data registers
//
// Behaviour
// - Five test pins; tester drives all but output
// - Sixteen-state controller stepped by test clock, mode
// - Own power-on reset forces test-logic-reset
// - Five-bit instruction selects register and pin behaviour
// - Unlisted codes act as bypass
// - External test drives and captures pins
// - Sample captures pins, preloads, leaves function alone
// - High-impedance floats pins, selects bypass
// - Clamp holds scan values, selects bypass
// - Identification code selects identification register
// - Bypass is one shift stage
// - Identification word: version, part, maker, one
// - Scan chain from data in to data out
// - Test and supply pins excluded from chain
// - Four cell types plus internal positions
// - Scan cells idle outside boundary instructions
// - Capture pins in parallel on rising clock
// - Fixed numbering, shared and per-pin control cells
`timescale 1ns/1ps
`include "bst_defs.svh"

module bst_tap #(
    parameter int          N          = `BST_CHAIN_LEN,
    parameter int          AUX_LEN    = `BST_AUX_LEN,
    parameter logic [3:0]  ID_VERSION = 4'h3,     // Arbitrary value
    parameter logic [15:0] ID_PART    = 16'h5A3C, // Arbitrary value
    parameter logic [10:0] ID_MAKER   = 11'h1C9   // Arbitrary value
) (
    input  logic                   core_clk_i,
    input  logic                   reset_i,
    input  bst_pkg::bst_tap_pins_t tap_i,
    output logic                   tdo_o,
    output logic                   tdo_oe_o,
    input  logic [N-1:0]           pin_in_i,
    input  logic [N-1:0]           core_out_i,
    input  logic [N-1:0]           core_oe_i,
    output logic [N-1:0]           pin_out_o,
    output logic [N-1:0]           pin_oe_o,
    output logic [N-1:0]           core_in_o,
    output logic                   test_mode_o
);
    import bst_pkg::*;

    localparam logic [N-1:0] MASK_O2 = N'(`BST_MASK_OUT2);
    localparam logic [N-1:0] MASK_IN = N'(`BST_MASK_INPUT);
    localparam logic [N-1:0] MASK_CT = N'(`BST_MASK_CTRL);
    localparam logic [N-1:0] MASK_BI = N'(`BST_MASK_BIDIR);
    localparam logic [N-1:0] MASK_DRV = MASK_O2 | MASK_BI;
    localparam logic [31:0]  ID_WORD = {ID_VERSION, ID_PART, ID_MAKER, `BST_ID_FIXED};

    bst_tap_pins_t          tap_s1_q;
    bst_tap_pins_t          tap_s2_q;
    logic                   tck_prev_q;
    logic [N-1:0]           pin_s1_q;
    logic [N-1:0]           pin_s2_q;
    bst_state_t             state_q;
    logic [`BST_IR_W-1:0]   ir_sh_q;
    logic [`BST_IR_W-1:0]   ir_q;
    logic                   byp_q;
    logic [31:0]            id_sh_q;
    logic [AUX_LEN-1:0]     aux_q;
    logic [N-1:0]           bsr_sh_q;
    logic [N-1:0]           bsr_upd_q;
    bst_sel_t               sel;
    logic                   sel_lsb;
    logic                   tck_rise;
    logic                   tck_fall;
    logic                   shifting;
    logic                   drive_scan;
    logic                   float_all;
    logic [N-1:0]           cap_vec;
    logic [N-1:0]           oe_d;
    logic [N-1:0]           out_d;
    // Control cell that gates a driven position
    function automatic int ctrl_of(input int pos);
        if (pos < `BST_GPIO_FIRST) begin
            return `BST_CTRL_LOW;
        end else if (pos <= `BST_GPIO_LAST) begin
            return pos + 1;
        end else if (pos <= `BST_CTRL_HI_LAST) begin
            return `BST_CTRL_HIGH;
        end
        return pos + 1;
    endfunction
    // Standard controller transition table
    function automatic bst_state_t next_state(input bst_state_t st, input logic tms);
        case (st)
            BST_TLR:    return tms ? BST_TLR    : BST_RTI;
            BST_RTI:    return tms ? BST_SEL_DR : BST_RTI;
            BST_SEL_DR: return tms ? BST_SEL_IR : BST_CAP_DR;
            BST_CAP_DR: return tms ? BST_EX1_DR : BST_SH_DR;
            BST_SH_DR:  return tms ? BST_EX1_DR : BST_SH_DR;
            BST_EX1_DR: return tms ? BST_UPD_DR : BST_PAU_DR;
            BST_PAU_DR: return tms ? BST_EX2_DR : BST_PAU_DR;
            BST_EX2_DR: return tms ? BST_UPD_DR : BST_SH_DR;
            BST_UPD_DR: return tms ? BST_SEL_DR : BST_RTI;
            BST_SEL_IR: return tms ? BST_TLR    : BST_CAP_IR;
            BST_CAP_IR: return tms ? BST_EX1_IR : BST_SH_IR;
            BST_SH_IR:  return tms ? BST_EX1_IR : BST_SH_IR;
            BST_EX1_IR: return tms ? BST_UPD_IR : BST_PAU_IR;
            BST_PAU_IR: return tms ? BST_EX2_IR : BST_PAU_IR;
            BST_EX2_IR: return tms ? BST_UPD_IR : BST_SH_IR;
            BST_UPD_IR: return tms ? BST_SEL_DR : BST_RTI;
            default:    return BST_TLR;
        endcase
    endfunction
    // Two-stage synchronisers for test pins and device pins
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            tap_s1_q   <= '0;
            tap_s2_q   <= '0;
            tck_prev_q <= 1'b0;
            pin_s1_q   <= '0;
            pin_s2_q   <= '0;
        end else begin
            tap_s1_q   <= tap_i;
            tap_s2_q   <= tap_s1_q;
            tck_prev_q <= tap_s2_q.tck;
            pin_s1_q   <= pin_in_i;
            pin_s2_q   <= pin_s1_q;
        end
    end
    // Test clock edges seen from the core clock
    assign tck_rise = tap_s2_q.tck & ~tck_prev_q;
    assign tck_fall = ~tap_s2_q.tck & tck_prev_q;
    assign shifting = (state_q == BST_SH_DR) || (state_q == BST_SH_IR);
    // Controller state
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            state_q <= BST_TLR;
        end else if (!tap_s2_q.trst_n) begin
            state_q <= BST_TLR;
        end else if (tck_rise) begin
            state_q <= next_state(state_q, tap_s2_q.tms);
        end
    end
    // Instruction shift stage
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            ir_sh_q <= `BST_IR_CAPTURE;
        end else if (tck_rise && state_q == BST_CAP_IR) begin
            ir_sh_q <= `BST_IR_CAPTURE;
        end else if (tck_rise && state_q == BST_SH_IR) begin
            ir_sh_q <= {tap_s2_q.tdi, ir_sh_q[`BST_IR_W-1:1]};
        end
    end
    // Active instruction, updated on the falling edge
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            ir_q <= `BST_OP_IDENT;
        end else if (state_q == BST_TLR) begin
            ir_q <= `BST_OP_IDENT;
        end else if (tck_fall && state_q == BST_UPD_IR) begin
            ir_q <= ir_sh_q;
        end
    end
    // Instruction decode to data register selection
    always_comb begin
        case (ir_q)
            `BST_OP_EXTEST:   sel = BST_SEL_BSR;
            `BST_OP_SAMPLE:   sel = BST_SEL_BSR;
            `BST_OP_HIGHZ:    sel = BST_SEL_BYP;
            `BST_OP_CLAMP:    sel = BST_SEL_BYP;
            `BST_OP_IDENT:    sel = BST_SEL_ID;
            `BST_OP_INT_SCAN: sel = BST_SEL_AUX;
            `BST_OP_MEM_TEST: sel = BST_SEL_AUX;
            `BST_OP_PRIVATE:  sel = BST_SEL_AUX;
            default:          sel = BST_SEL_BYP;
        endcase
    end
    // Pin modes derived from the instruction
    assign drive_scan = (ir_q == `BST_OP_EXTEST) || (ir_q == `BST_OP_CLAMP);
    assign float_all  = (ir_q == `BST_OP_HIGHZ);
    // Parallel capture value by cell type
    assign cap_vec = ((MASK_IN | MASK_BI) & pin_s2_q)
                   | (MASK_O2 & core_out_i)
                   | (MASK_CT & core_oe_i);
    // Bypass stage
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            byp_q <= `BST_BYP_CAPTURE;
        end else if (tck_rise && sel == BST_SEL_BYP) begin
            if (state_q == BST_CAP_DR) begin
                byp_q <= `BST_BYP_CAPTURE;
            end else if (state_q == BST_SH_DR) begin
                byp_q <= tap_s2_q.tdi;
            end
        end
    end
    // Identification shift register, read-only contents
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            id_sh_q <= '0;
        end else if (tck_rise && sel == BST_SEL_ID) begin
            if (state_q == BST_CAP_DR) begin
                id_sh_q <= ID_WORD;
            end else if (state_q == BST_SH_DR) begin
                id_sh_q <= {tap_s2_q.tdi, id_sh_q[31:1]};
            end
        end
    end
    // Shared path for internal, self-test and private instructions
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            aux_q <= '0;
        end else if (tck_rise && sel == BST_SEL_AUX) begin
            if (state_q == BST_CAP_DR) begin
                aux_q <= '0;
            end else if (state_q == BST_SH_DR) begin
                aux_q <= {tap_s2_q.tdi, aux_q[AUX_LEN-1:1]};
            end
        end
    end
    // Boundary chain shift stages, cell 0 nearest data out
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            bsr_sh_q <= '0;
        end else if (tck_rise && sel == BST_SEL_BSR) begin
            if (state_q == BST_CAP_DR) begin
                bsr_sh_q <= cap_vec;
            end else if (state_q == BST_SH_DR) begin
                bsr_sh_q <= {tap_s2_q.tdi, bsr_sh_q[N-1:1]};
            end
        end
    end
    // Boundary chain update stages, loaded on the falling edge
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            bsr_upd_q <= '0;
        end else if (tck_fall && state_q == BST_UPD_DR && sel == BST_SEL_BSR) begin
            bsr_upd_q <= bsr_sh_q;
        end
    end
    // Serial output source
    always_comb begin
        if (state_q == BST_SH_IR) begin
            sel_lsb = ir_sh_q[0];
        end else begin
            case (sel)
                BST_SEL_BSR: sel_lsb = bsr_sh_q[0];
                BST_SEL_ID:  sel_lsb = id_sh_q[0];
                BST_SEL_AUX: sel_lsb = aux_q[0];
                default:     sel_lsb = byp_q;
            endcase
        end
    end
    // Data out changes only on the falling edge
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            tdo_o    <= 1'b0;
            tdo_oe_o <= 1'b0;
        end else if (tck_fall) begin
            tdo_o    <= sel_lsb;
            tdo_oe_o <= shifting;
        end
    end
    // Per-position drive enable: output2 on unless high-impedance, bidirectional from its control cell
    for (genvar i = 0; i < N; i++) begin : g_cell
        localparam int C = ctrl_of(i);
        if (MASK_O2[i]) begin : g_out2
            assign oe_d[i] = ~float_all;
        end else if (MASK_BI[i] && C < N) begin : g_bidir
            assign oe_d[i] = ~float_all & (drive_scan ? bsr_upd_q[C] : core_oe_i[C]);
        end else begin : g_none
            assign oe_d[i] = 1'b0;
        end
    end
    // Pin value: scan cells in external test and clamp, zero in high-impedance, core otherwise
    assign out_d = MASK_DRV & (float_all ? '0 : (drive_scan ? bsr_upd_q : core_out_i));
    // Registered pin and mode outputs
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            pin_out_o   <= '0;
            pin_oe_o    <= '0;
            core_in_o   <= '0;
            test_mode_o <= 1'b0;
        end else begin
            pin_out_o   <= out_d;
            pin_oe_o    <= oe_d;
            core_in_o   <= pin_s2_q & (MASK_IN | MASK_BI);
            test_mode_o <= drive_scan | float_all;
        end
    end
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (reset_i);
    sequence s_cap_dr;
        tck_rise && state_q == BST_CAP_DR;
    endsequence
    sequence s_upd_ir;
        tck_fall && state_q == BST_UPD_IR;
    endsequence
    property p_trst_forces_reset;
        !tap_s2_q.trst_n |=> state_q == BST_TLR;
    endproperty
    a_trst_forces_reset: assert property (p_trst_forces_reset)
        else $error("test reset did not force test-logic-reset");
    property p_shift_exit;
        (tck_rise && state_q == BST_SH_DR && tap_s2_q.tms) |=> state_q == BST_EX1_DR;
    endproperty
    a_shift_exit: assert property (p_shift_exit)
        else $error("shift-dr with mode high did not go to exit1");
    property p_reset_loads_ident;
        state_q == BST_TLR |=> ir_q == `BST_OP_IDENT;
    endproperty
    a_reset_loads_ident: assert property (p_reset_loads_ident)
        else $error("identification instruction not loaded in reset state");
    property p_ir_update;
        s_upd_ir |=> ir_q == $past(ir_sh_q);
    endproperty
    a_ir_update: assert property (p_ir_update)
        else $error("instruction not updated from shift stage");
    property p_unlisted_bypass;
        !(ir_q inside {`BST_OP_EXTEST, `BST_OP_SAMPLE, `BST_OP_IDENT, `BST_OP_INT_SCAN,
                       `BST_OP_MEM_TEST, `BST_OP_PRIVATE}) |-> sel == BST_SEL_BYP;
    endproperty
    a_unlisted_bypass: assert property (p_unlisted_bypass)
        else $error("unlisted instruction did not select bypass");
    property p_highz_floats;
        float_all ##1 float_all |-> pin_oe_o == '0;
    endproperty
    a_highz_floats: assert property (p_highz_floats)
        else $error("pin driven during high-impedance instruction");
    property p_scan_drives_pins;
        drive_scan ##1 drive_scan |-> pin_out_o == ($past(bsr_upd_q) & MASK_DRV);
    endproperty
    a_scan_drives_pins: assert property (p_scan_drives_pins)
        else $error("pins not driven from update stages");
    property p_sample_transparent;
        (ir_q == `BST_OP_SAMPLE) ##1 (ir_q == `BST_OP_SAMPLE)
            |-> pin_out_o == ($past(core_out_i) & MASK_DRV);
    endproperty
    a_sample_transparent: assert property (p_sample_transparent)
        else $error("sample disturbed normal pin values");
    property p_ident_capture;
        (s_cap_dr and sel == BST_SEL_ID) |=> id_sh_q == ID_WORD;
    endproperty
    a_ident_capture: assert property (p_ident_capture)
        else $error("identification word not captured");
    property p_bypass_capture;
        (s_cap_dr and sel == BST_SEL_BYP) |=> byp_q == `BST_BYP_CAPTURE;
    endproperty
    a_bypass_capture: assert property (p_bypass_capture)
        else $error("bypass stage not cleared on capture");
    property p_chain_capture;
        (s_cap_dr and sel == BST_SEL_BSR) |=> bsr_sh_q == $past(cap_vec);
    endproperty
    a_chain_capture: assert property (p_chain_capture)
        else $error("boundary chain parallel capture wrong");
    property p_chain_shift;
        (tck_rise && state_q == BST_SH_DR && sel == BST_SEL_BSR)
            |=> bsr_sh_q[N-1] == $past(tap_s2_q.tdi);
    endproperty
    a_chain_shift: assert property (p_chain_shift)
        else $error("boundary chain did not take data in");
    property p_tdo_on_fall;
        (tck_fall && shifting) |=> tdo_o == $past(sel_lsb) && tdo_oe_o;
    endproperty
    a_tdo_on_fall: assert property (p_tdo_on_fall)
        else $error("data out not updated on falling edge");
endmodule

// ==== testbench/bst_tester.sv ====
// Tester model driving the boundary-scan pins
`timescale 1ns/1ps

module bst_tester (
    input  logic                   core_clk_i,
    input  logic                   tdo_i,
    input  logic                   tdo_oe_i,
    output bst_pkg::bst_tap_pins_t tap_o
);
    import bst_pkg::*;

    // Idle levels: test clock parked low, test reset released
    initial tap_o = '{tck: 1'b0, tms: 1'b1, tdi: 1'b0, trst_n: 1'b1};

    // One test clock period; inputs move one core cycle after the fall
    task automatic tick(input logic ms, input logic di, output logic q, output logic oe);
        @(posedge core_clk_i);
        #1;
        tap_o.tms = ms;
        tap_o.tdi = di;
        repeat (15) @(posedge core_clk_i);
        #1;
        q = tdo_oe_i ? tdo_i : ~tdo_i; // Released line reads inverted
        oe = tdo_oe_i;
        tap_o.tck = 1'b1;
        repeat (16) @(posedge core_clk_i);
        #1;
        tap_o.tck = 1'b0;
    endtask

    // Data line toggles outside shifts so no stale value lingers
    function automatic logic fill();
        return ~tap_o.tdi;
    endfunction

    // Step from test-logic-reset to idle
    task automatic go_idle();
        logic q;
        logic oe;
        tick(1'b0, fill(), q, oe);
    endtask

    // Five ones on mode select reach test-logic-reset from any state
    task automatic tms_reset();
        logic q;
        logic oe;
        repeat (5) tick(1'b1, fill(), q, oe);
        go_idle();
    endtask

    // Pulse the active-low test reset pin
    task automatic pulse_trst();
        @(posedge core_clk_i);
        #1;
        tap_o.trst_n = 1'b0;
        repeat (8) @(posedge core_clk_i);
        #1;
        tap_o.trst_n = 1'b1;
        go_idle();
    endtask

    // Scan from idle: capture, shift len bits LSB first, update, back to idle
    task automatic scan(input logic ir, input int len, input logic [63:0] din,
                        output logic [63:0] dout, output logic oe_ok);
        logic q;
        logic oe;
        dout = '0;
        oe_ok = 1'b1;
        tick(1'b1, fill(), q, oe);
        if (ir) tick(1'b1, fill(), q, oe);
        tick(1'b0, fill(), q, oe);
        tick(1'b0, fill(), q, oe);
        for (int i = 0; i < len; i++) begin
            tick(i == len - 1, din[i], q, oe);
            dout[i] = q;
            oe_ok &= oe;
        end
        tick(1'b1, fill(), q, oe);
        tick(1'b0, fill(), q, oe);
    endtask
endmodule

// ==== testbench/tb.sv ====
// Testbench for the boundary-scan test access port
`timescale 1ns/1ps
`include "bst_defs.svh"

module tb;
    import bst_pkg::*;

    localparam int           N       = `BST_CHAIN_LEN;
    localparam logic [3:0]   VER     = 4'h6;      // Arbitrary value
    localparam logic [15:0]  PART    = 16'hB2D1;  // Arbitrary value
    localparam logic [10:0]  MAKER   = 11'h2A7;   // Arbitrary value
    localparam logic [31:0]  ID_WORD = {VER, PART, MAKER, 1'b1};
    localparam logic [N-1:0] DRV     = `BST_MASK_OUT2 | `BST_MASK_BIDIR;
    localparam logic [N-1:0] SENSE   = `BST_MASK_INPUT | `BST_MASK_BIDIR;
    localparam logic [N-1:0] PRE     = 57'h1234567890ABCDE;
    localparam logic [N-1:0] NXT     = 57'h0FEDCBA98765432;

    logic          core_clk;
    logic          reset;
    bst_tap_pins_t tap;
    logic          tdo;
    logic          tdo_oe;
    logic          test_mode;
    logic [N-1:0]  pin_in;
    logic [N-1:0]  core_out;
    logic [N-1:0]  core_oe;
    logic [N-1:0]  pin_out;
    logic [N-1:0]  pin_oe;
    logic [N-1:0]  core_in;
    logic [63:0]   dout;
    logic          oe_ok;
    int            fail_count;
    int            checked;
    int            bpos[9]      = '{6, 18, 19, 33, 35, 42, 47, 48, 55};
    int            cpos[9]      = '{12, 12, 20, 34, 45, 45, 45, 49, 56};
    logic [4:0]    byp_codes[6] = '{5'h1F, 5'h03, 5'h11, 5'h1E, `BST_OP_HIGHZ, `BST_OP_CLAMP};
    logic [4:0]    aux_codes[3] = '{`BST_OP_INT_SCAN, `BST_OP_PRIVATE, `BST_OP_MEM_TEST};

    // Core clock, 5 ns period
    initial core_clk = 1'b0;
    always #2.5 core_clk = ~core_clk;

    bst_tap #(.N(N), .AUX_LEN(`BST_AUX_LEN), .ID_VERSION(VER), .ID_PART(PART),
              .ID_MAKER(MAKER)) u_dut (
        .core_clk_i  (core_clk),
        .reset_i     (reset),
        .tap_i       (tap),
        .tdo_o       (tdo),
        .tdo_oe_o    (tdo_oe),
        .pin_in_i    (pin_in),
        .core_out_i  (core_out),
        .core_oe_i   (core_oe),
        .pin_out_o   (pin_out),
        .pin_oe_o    (pin_oe),
        .core_in_o   (core_in),
        .test_mode_o (test_mode)
    );

    bst_tester u_tester (
        .core_clk_i (core_clk),
        .tdo_i      (tdo),
        .tdo_oe_i   (tdo_oe),
        .tap_o      (tap)
    );

    // Compare one result and count it
    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Verdict and end of run
    task automatic finish_test();
        if (fail_count == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Let a few core cycles pass
    task automatic settle();
        repeat (8) @(posedge core_clk);
        #1;
    endtask

    // Load an instruction; the capture pattern comes back
    task automatic load(input logic [4:0] code);
        u_tester.scan(1'b1, 5, 64'(code), dout, oe_ok);
        chk(dout, 64'(`BST_IR_CAPTURE), "instruction capture");
    endtask

    // Scan a data register and compare what came out
    task automatic read_dr(input int len, input logic [63:0] din, input logic [63:0] exp);
        u_tester.scan(1'b0, len, din, dout, oe_ok);
        chk(dout, exp, "data scan");
        chk(64'(oe_ok), 64'h1, "output enable in shift");
    endtask

    // Boundary capture expected from present pin and core levels
    function automatic logic [63:0] cap_exp();
        return 64'((core_out & `BST_MASK_OUT2) | (pin_in & SENSE) | (core_oe & `BST_MASK_CTRL));
    endfunction

    // Bidirectional enables follow their control source; output cells drive
    task automatic chk_oe(input logic [N-1:0] src);
        for (int k = 0; k < 9; k++) begin
            chk(64'(pin_oe[bpos[k]]), 64'(src[cpos[k]]), "bidir enable");
        end
        chk(64'({pin_oe[0], pin_oe[1], pin_oe[54]}), 64'h7, "output2 enable");
    endtask

    // Watchdog on the whole run
    initial begin
        repeat (100000) @(posedge core_clk);
        fail_count++;
        $display("BAD %0t run did not finish", $time);
        finish_test();
    end

    // Main sequence
    initial begin
        reset = 1'b1;
        pin_in = '0;
        core_out = '0;
        core_oe = '0;
        fail_count = 0;
        checked = 0;
        repeat (12) @(posedge core_clk);
        #1;
        reset = 1'b0;
        settle();
        u_tester.go_idle();
        read_dr(40, 64'hA5, {24'h0, 8'hA5, ID_WORD});
        chk(64'(tdo_oe), 64'h0, "output enable idle");
        // Bypass-type and unlisted codes: one stage capturing zero
        foreach (byp_codes[k]) begin
            load(byp_codes[k]);
            read_dr(8, 64'h96, 64'h2C);
            chk(64'(test_mode), 64'(byp_codes[k] inside {`BST_OP_HIGHZ, `BST_OP_CLAMP}),
                "test mode");
            if (byp_codes[k] == `BST_OP_HIGHZ) begin
                chk(64'(pin_oe | pin_out), 64'h0, "high impedance pins");
            end
        end
        // Internal paths: eight stages capturing zero
        foreach (aux_codes[k]) begin
            load(aux_codes[k]);
            read_dr(16, 64'hC3A5, 64'hA500);
        end
        // Sample leaves the pins with the core
        pin_in = 57'h15A5A5AC3C30F0F;
        core_out = 57'h0F0F0F0F0F0F0F1;
        core_oe = 57'h0AA2005050010FF;
        settle();
        load(`BST_OP_SAMPLE);
        chk(64'(pin_out), 64'(core_out & DRV), "pins in sample");
        chk_oe(core_oe);
        chk(64'(core_in), 64'(pin_in & SENSE), "core inputs");
        read_dr(N, 64'(PRE), cap_exp());
        // External test drives the preloaded cells
        load(`BST_OP_EXTEST);
        chk(64'(test_mode), 64'h1, "test mode extest");
        chk(64'(pin_out), 64'(PRE & DRV), "pins in extest");
        chk_oe(PRE);
        pin_in = 57'h0E1E1E1E1E1E1E1;
        settle();
        read_dr(N, 64'(NXT), cap_exp());
        chk(64'(pin_out), 64'(NXT & DRV), "pins after update");
        // Clamp keeps the last update on the pins
        load(`BST_OP_CLAMP);
        chk(64'(pin_out), 64'(NXT & DRV), "pins in clamp");
        // Mode-select reset restores identification and core pins
        u_tester.tms_reset();
        read_dr(32, 64'h0, 64'(ID_WORD));
        chk(64'(pin_out), 64'(core_out & DRV), "pins after reset");
        // Test reset pin from bypass
        load(`BST_OP_BYPASS);
        u_tester.pulse_trst();
        read_dr(32, 64'h0, 64'(ID_WORD));
        // Power-on reset in mid-run
        load(`BST_OP_BYPASS);
        reset = 1'b1;
        settle();
        reset = 1'b0;
        settle();
        u_tester.go_idle();
        read_dr(32, 64'h0, 64'(ID_WORD));
        finish_test();
    end
endmodule
